// ===== src/lq_front_end.sv
// How it works
// - queue holds 18 entries, stalls writes when fewer than six are free
// - at most five instructions leave per cycle
// - only loops shorter than 18 get locked
// - locked loop replays until misprediction
// - fetch, predictor, predecode idle while locked
// - replay has no taken-branch or prefix bubbles
// - decoder zero takes flows up to four
// - other decoders single flow or stack op, all fuse, track
// - microsequencer emits up to three micro-ops per cycle
// - qualifying adjacent pair becomes one micro-op
// - one fusion per cycle, none in 64-bit
// - decoders compute implicit stack-pointer updates
// - push, pop, return decode to one
// - micro-fused flow leaves as one entry
module lq_front_end #(
    // queue geometry; five-bit pointers and count keep the depth at or below 31
    parameter int unsigned DEPTH = lq_pkg::QUEUE_DEPTH,
    parameter int unsigned LANES = lq_pkg::PD_LANES,
    parameter int unsigned DELIVER = lq_pkg::DELIVER_MAX
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // predecode write side
    input wire logic [LANES-1:0] pd_valid,
    input wire lq_pkg::lq_entry_t [LANES-1:0] pd_entry,
    output logic pd_ready,
    // core control
    input wire logic mispredict,
    input wire logic mode_64,
    // status
    output logic fe_idle,
    // micro-op side toward the renamer
    input wire logic out_ready,
    output logic out_valid,
    output logic ms_active,
    output logic [3:0] dec_valid,
    output logic [3:0][7:0] dec_tag,
    output logic [3:0][7:0] dec_tag2,
    output logic [3:0][2:0] dec_nuops,
    output logic [3:0] dec_macro_fused,
    output logic [3:0] dec_micro_fused,
    output logic [3:0][7:0] dec_sp_ofs,
    output logic [3:0] dec_sp_sync
);

    // whole state: queue, loop lock, tracker and the registered outputs
    typedef struct packed {
        lq_pkg::lq_entry_t [DEPTH-1:0] mem;
        logic [4:0] head;
        logic [4:0] tail;
        logic [4:0] count;
        logic locked;
        logic [4:0] lstart;
        logic [4:0] lend;
        logic [3:0] ms_rem;
        logic [7:0] sp_ofs;
        logic pd_ready;
        logic out_valid;
        logic ms_active;
        logic [3:0] dec_valid;
        logic [3:0][7:0] dec_tag;
        logic [3:0][7:0] dec_tag2;
        logic [3:0][2:0] dec_nuops;
        logic [3:0] dec_macro_fused;
        logic [3:0] dec_micro_fused;
        logic [3:0][7:0] dec_sp_ofs;
        logic [3:0] dec_sp_sync;
    } lq_state_t;

    // current state and its next value
    lq_state_t st_r;
    lq_state_t st_nxt;

    // next read slot; inside a locked loop the last body entry wraps to the first
    function automatic logic [4:0] lq_adv(input logic [4:0] p, input logic lk,
                                          input logic [4:0] le, input logic [4:0] ls);
        logic [4:0] r;
        r = (p == 5'(DEPTH - 1)) ? lq_pkg::PTR_RESET : p + 5'h01;
        if (lk && p == le) begin
            r = ls;
        end
        return r;
    endfunction : lq_adv

    // decode, queue bookkeeping and loop lock in one pass
    always_comb begin
        logic [4:0] rd;
        logic [4:0] avail;
        logic [4:0] used;
        logic [4:0] wcnt;
        logic [4:0] cnt_nxt;
        logic [2:0] d;
        logic stop;
        logic pair;
        logic fdone;
        logic cand;
        logic [4:0] cand_end;
        logic [4:0] cand_len;
        logic [5:0] ls_wide;
        logic [7:0] wsz;
        logic [3:0] chunk;
        lq_pkg::lq_entry_t e;
        lq_pkg::lq_entry_t e2;
        // scratch values start clean so no latch is inferred
        st_nxt = st_r;
        rd = st_r.head;
        used = 5'h00;
        wcnt = 5'h00;
        cnt_nxt = 5'h00;
        d = 3'h0;
        stop = 1'b0;
        pair = 1'b0;
        fdone = 1'b0;
        cand = 1'b0;
        cand_end = lq_pkg::PTR_RESET;
        cand_len = 5'h00;
        ls_wide = 6'h00;
        chunk = 4'h0;
        e = '0;
        e2 = '0;
        // stack word follows the operating mode
        wsz = mode_64 ? lq_pkg::SP_WORD_64 : lq_pkg::SP_WORD_32;
        // a locked loop never runs dry, so replay can offer the full width every cycle
        avail = st_r.locked ? 5'(DELIVER) : st_r.count;
        if (avail > 5'(DELIVER)) begin
            avail = 5'(DELIVER);
        end
        // a held group stays untouched until the renamer takes it or a misprediction drops it
        if (!st_r.out_valid || out_ready) begin
            st_nxt.out_valid = 1'b0;
            st_nxt.ms_active = 1'b0;
            st_nxt.dec_valid = 4'h0;
            st_nxt.dec_macro_fused = 4'h0;
            st_nxt.dec_micro_fused = 4'h0;
            st_nxt.dec_sp_sync = 4'h0;
            if (st_r.ms_rem != 4'h0) begin
                // microsequencer owns decoder zero until the long flow is out
                chunk = (st_r.ms_rem > lq_pkg::MS_UOPS) ? lq_pkg::MS_UOPS : st_r.ms_rem;
                st_nxt.ms_rem = st_r.ms_rem - chunk;
                st_nxt.ms_active = 1'b1;
                st_nxt.out_valid = 1'b1;
                st_nxt.dec_valid[0] = 1'b1;
                st_nxt.dec_nuops[0] = chunk[2:0];
            end else begin
                // walk the queue head slot by slot; a stopped walk keeps the rest in order
                for (int i = 0; i < DELIVER; i++) begin
                    if (!stop && used < avail) begin
                        // look one entry ahead so a fused pair is seen whole
                        e = st_r.mem[rd];
                        e2 = st_r.mem[lq_adv(rd, st_r.locked, st_r.lend, st_r.lstart)];
                        if (pair) begin
                            // second half of a fused pair rides in the same decoder
                            st_nxt.dec_tag2[d - 3'h1] = e.tag;
                            pair = 1'b0;
                            used = used + 5'h01;
                            rd = lq_adv(rd, st_r.locked, st_r.lend, st_r.lstart);
                        end else if (d == 3'h4) begin
                            stop = 1'b1;
                        end else if (e.nuops > lq_pkg::DEC0_MAX_UOPS) begin
                            // long flows start only on decoder zero and end the group
                            if (d == 3'h0) begin
                                st_nxt.ms_rem = e.nuops - lq_pkg::MS_UOPS;
                                st_nxt.ms_active = 1'b1;
                                st_nxt.dec_valid[0] = 1'b1;
                                st_nxt.dec_tag[0] = e.tag;
                                st_nxt.dec_tag2[0] = 8'h00;
                                st_nxt.dec_nuops[0] = lq_pkg::MS_UOPS[2:0];
                                // tracker offset must not leak from the previous group
                                st_nxt.dec_sp_ofs[0] = st_nxt.sp_ofs;
                                used = used + 5'h01;
                                rd = lq_adv(rd, st_r.locked, st_r.lend, st_r.lstart);
                            end
                            stop = 1'b1;
                        end else if (e.nuops > 4'h1 && e.sp_op == lq_pkg::LQ_SP_NONE && d != 3'h0) begin
                            // a multi-micro-op flow with no stack operation waits for decoder zero so program order holds
                            stop = 1'b1;
                        end else begin
                            st_nxt.dec_valid[d[1:0]] = 1'b1;
                            st_nxt.dec_tag[d[1:0]] = e.tag;
                            st_nxt.dec_tag2[d[1:0]] = 8'h00;
                            st_nxt.dec_nuops[d[1:0]] = e.nuops[2:0];
                            // a micro-fused flow is one entry all the way to dispatch
                            st_nxt.dec_micro_fused[d[1:0]] = e.micro_fused;
                            // stack-pointer tracker: the update never becomes a micro-op
                            unique case (e.sp_op)
                                lq_pkg::LQ_SP_PUSH, lq_pkg::LQ_SP_CALL: begin
                                    st_nxt.sp_ofs = st_nxt.sp_ofs - wsz;
                                end
                                lq_pkg::LQ_SP_POP, lq_pkg::LQ_SP_RET: begin
                                    st_nxt.sp_ofs = st_nxt.sp_ofs + wsz;
                                end
                                lq_pkg::LQ_SP_LEAVE: begin
                                    st_nxt.sp_ofs = wsz;
                                    st_nxt.dec_sp_sync[d[1:0]] = 1'b1;
                                end
                                default: begin
                                end
                            endcase
                            // push, pop and return stay single flows, the tracker absorbs the rest
                            if (e.sp_op == lq_pkg::LQ_SP_PUSH || e.sp_op == lq_pkg::LQ_SP_POP ||
                                e.sp_op == lq_pkg::LQ_SP_RET) begin
                                st_nxt.dec_nuops[d[1:0]] = 3'h1;
                            end
                            // each decoder reports the offset after its own instruction
                            st_nxt.dec_sp_ofs[d[1:0]] = st_nxt.sp_ofs;
                            // a fused pair takes one decoder and two delivery slots, never on the 64-bit path
                            if (!mode_64 && !fdone && i < 4 && e.fuse_cmp && e2.fuse_jcc &&
                                used + 5'h01 < avail) begin
                                st_nxt.dec_macro_fused[d[1:0]] = 1'b1;
                                st_nxt.dec_nuops[d[1:0]] = 3'h1;
                                pair = 1'b1;
                                fdone = 1'b1;
                            end
                            // on to the next decoder and queue entry
                            d = d + 3'h1;
                            used = used + 5'h01;
                            rd = lq_adv(rd, st_r.locked, st_r.lend, st_r.lstart);
                        end
                    end
                end
                // a group is shown if a decoder or the microsequencer took work
                st_nxt.out_valid = (d != 3'h0) || st_nxt.ms_active;
            end
        end
        // head moves past everything taken this cycle
        st_nxt.head = rd;
        // predecode writes only into guaranteed free room; nothing is written while locked
        if (st_r.pd_ready && !st_r.locked) begin
            for (int j = 0; j < LANES; j++) begin
                if (pd_valid[j]) begin
                    st_nxt.mem[st_nxt.tail] = pd_entry[j];
                    if (pd_entry[j].loop_end && pd_entry[j].loop_len != 5'h00 &&
                        pd_entry[j].loop_len < 5'(DEPTH)) begin
                        cand = 1'b1;
                        cand_end = st_nxt.tail;
                        cand_len = pd_entry[j].loop_len;
                    end
                    st_nxt.tail = (st_nxt.tail == 5'(DEPTH - 1)) ? lq_pkg::PTR_RESET : st_nxt.tail + 5'h01;
                    wcnt = wcnt + 5'h01;
                end
            end
        end
        // replayed entries are not freed: the body stays locked in place
        cnt_nxt = st_r.count - (st_r.locked ? 5'h00 : used) + wcnt;
        st_nxt.count = cnt_nxt;
        // lock only if the queue still holds at least as many entries as the body
        if (cand && cnt_nxt >= cand_len) begin
            ls_wide = {1'b0, cand_end} + 6'(DEPTH) + 6'h01 - {1'b0, cand_len};
            if (ls_wide >= 6'(DEPTH)) begin
                ls_wide = ls_wide - 6'(DEPTH);
            end
            st_nxt.locked = 1'b1;
            st_nxt.lstart = ls_wide[4:0];
            st_nxt.lend = cand_end;
        end
        // room for a whole predecode burst keeps lanes from being dropped
        st_nxt.pd_ready = !st_nxt.locked && (5'(DEPTH) - cnt_nxt) >= 5'(LANES);
        // misprediction wins over everything in the same cycle
        if (mispredict) begin
            // loop lock, tracker and any pending long flow restart clean
            st_nxt.head = lq_pkg::PTR_RESET;
            st_nxt.tail = lq_pkg::PTR_RESET;
            st_nxt.count = 5'h00;
            st_nxt.locked = 1'b0;
            st_nxt.ms_rem = 4'h0;
            st_nxt.ms_active = 1'b0;
            st_nxt.sp_ofs = lq_pkg::SP_OFS_RESET;
            st_nxt.out_valid = 1'b0;
            st_nxt.dec_valid = 4'h0;
            st_nxt.pd_ready = 1'b1;
        end
    end

    // single state register; ready toward predecode comes up one edge after reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // all outputs straight from the state register
    assign pd_ready = st_r.pd_ready;
    assign fe_idle = st_r.locked;
    assign out_valid = st_r.out_valid;
    assign ms_active = st_r.ms_active;
    assign dec_valid = st_r.dec_valid;
    assign dec_tag = st_r.dec_tag;
    assign dec_tag2 = st_r.dec_tag2;
    assign dec_nuops = st_r.dec_nuops;
    assign dec_macro_fused = st_r.dec_macro_fused;
    assign dec_micro_fused = st_r.dec_micro_fused;
    assign dec_sp_ofs = st_r.dec_sp_ofs;
    assign dec_sp_sync = st_r.dec_sp_sync;

endmodule : lq_front_end

// ===== src/lq_pkg.sv
package lq_pkg;

    // queue geometry and per-cycle limits
    localparam int unsigned QUEUE_DEPTH = 18;
    localparam int unsigned LOOP_LIMIT = 18;
    localparam int unsigned DELIVER_MAX = 5;
    localparam int unsigned PD_LANES = 6;
    localparam int unsigned NUM_DEC = 4;
    localparam logic [3:0] DEC0_MAX_UOPS = 4'h4;
    localparam logic [3:0] MS_UOPS = 4'h3;

    // pointer and count encodings
    localparam logic [4:0] PTR_LAST = 5'h11;
    localparam logic [4:0] PTR_RESET = 5'h00;
    localparam logic [4:0] DEPTH_VAL = 5'h12;
    localparam logic [4:0] LANES_VAL = 5'h06;
    localparam logic [2:0] DELIVER_VAL = 3'h5;
    localparam logic [5:0] DEPTH_WIDE = 6'h12;

    // stack word sizes in bytes
    localparam logic [7:0] SP_WORD_32 = 8'h04;
    localparam logic [7:0] SP_WORD_64 = 8'h08;
    localparam logic [7:0] SP_OFS_RESET = 8'h00;

    // implicit stack-pointer operation of an instruction
    typedef enum logic [2:0] {
        LQ_SP_NONE  = 3'b000,
        LQ_SP_PUSH  = 3'b001,
        LQ_SP_POP   = 3'b010,
        LQ_SP_CALL  = 3'b011,
        LQ_SP_LEAVE = 3'b100,
        LQ_SP_RET   = 3'b101
    } lq_sp_op_t;

    // one predecoded instruction as held in the queue
    typedef struct packed {
        logic [7:0] tag;
        logic [3:0] nuops;
        logic micro_fused;
        lq_sp_op_t sp_op;
        logic fuse_cmp;
        logic fuse_jcc;
        logic loop_end;
        logic [4:0] loop_len;
    } lq_entry_t;

endpackage : lq_pkg

// ===== test/lq_fe_checker.sv
module lq_fe_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // control and status
    input wire logic pd_ready,
    input wire logic mispredict,
    input wire logic mode_64,
    input wire logic fe_idle,
    // micro-op side
    input wire logic out_ready,
    input wire logic out_valid,
    input wire logic ms_active,
    input wire logic [3:0] dec_valid,
    input wire logic [3:0][7:0] dec_tag,
    input wire logic [3:0][2:0] dec_nuops,
    input wire logic [3:0] dec_macro_fused
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // a held group that no flush will drop, and the state a flush must leave
    sequence s_stall;
        out_valid && !out_ready && !mispredict;
    endsequence
    sequence s_flushed;
        !out_valid && !fe_idle && pd_ready;
    endsequence

    a_hold_stall: assert property (s_stall |=> out_valid && $stable({dec_valid, dec_tag, dec_nuops}))
        else $error("group changed while stalled");
    a_flush_clear: assert property (mispredict |=> s_flushed)
        else $error("flush left state behind");
    a_idle_closed: assert property (fe_idle |-> !pd_ready)
        else $error("writes open while locked");
    a_lock_holds: assert property (fe_idle && !mispredict |=> fe_idle)
        else $error("lock dropped without flush");
    a_dec0_size: assert property (out_valid && dec_valid[0] |-> dec_nuops[0] <= 3'h4)
        else $error("decoder zero flow too long");
    a_one_fusion: assert property (out_valid |-> $onehot0(dec_macro_fused & dec_valid))
        else $error("two fusions in one group");
    a_no_fuse64: assert property (out_valid && mode_64 && $past(mode_64) |-> dec_macro_fused == 4'h0)
        else $error("fusion in 64-bit mode");
    a_ms_chunk: assert property (ms_active && out_valid |-> dec_valid == 4'h1 && dec_nuops[0] inside {[1:3]})
        else $error("bad microsequencer chunk");
    a_contig: assert property (out_valid |-> dec_valid inside {4'h1, 4'h3, 4'h7, 4'hf})
        else $error("decoder valids not packed");
endmodule : lq_fe_checker

// ===== test/lq_renamer_model.sv
module lq_renamer_model (
    // clock
    input wire logic sys_clk,
    // stall request from the bench
    input wire logic hold,
    // handshake toward the decoders
    output logic out_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    // ready moves on the falling edge only, so every taken group is a whole-cycle decision
    initial out_ready = 1'b0;
    always @(negedge sys_clk) begin
        out_ready <= hold ? 1'b0 : ($urandom_range(3) != 0);
    end
endmodule : lq_renamer_model

// ===== test/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] tag;
        logic [7:0] tag2;
        logic [2:0] nu;
        logic mac;
        logic mic;
        logic [7:0] ofs;
        logic snc;
    } lq_exp_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] pd_valid = 6'h00;
    lq_pkg::lq_entry_t [5:0] pd_entry = '0;
    logic mispredict = 1'b0;
    logic mode_64 = 1'b0;
    logic hold = 1'b1;
    logic pd_ready, fe_idle, out_ready, out_valid, ms_active;
    logic [3:0] dec_valid, dec_macro_fused, dec_micro_fused, dec_sp_sync;
    logic [3:0][7:0] dec_tag, dec_tag2, dec_sp_ofs;
    logic [3:0][2:0] dec_nuops;
    lq_exp_t expq[$];
    lq_exp_t e;
    int bad_count = 0;
    int samples_checked = 0;
    logic [7:0] ofs = 8'h00;
    logic snc = 1'b0;
    logic [7:0] nt = 8'h10;

    always #4 sys_clk = ~sys_clk;

    lq_front_end u_lq_front_end (.sys_clk, .rst_n, .pd_valid, .pd_entry, .pd_ready, .mispredict, .mode_64,
        .fe_idle, .out_ready, .out_valid, .ms_active, .dec_valid, .dec_tag, .dec_tag2, .dec_nuops,
        .dec_macro_fused, .dec_micro_fused, .dec_sp_ofs, .dec_sp_sync);
    lq_renamer_model u_lq_renamer_model (.sys_clk, .hold, .out_ready);

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    function automatic lq_pkg::lq_entry_t ent(input logic [7:0] t, input logic [3:0] nu,
        input lq_pkg::lq_sp_op_t sp, input logic [3:0] fl, input logic [4:0] ll);
        return '{t, nu, fl[3], sp, fl[2], fl[1], fl[0], ll};
    endfunction : ent

    task automatic ex(input logic [7:0] t, input logic [7:0] t2, input logic [2:0] nu, input logic mac,
        input logic mic);
        expq.push_back('{t, t2, nu, mac, mic, ofs, snc});
    endtask : ex

    // predecode side: request set on the falling edge, held over the taking edge
    task automatic wr(input int n);
        for (int k = 0; k < 300 && pd_ready !== 1'b1; k++) @(negedge sys_clk);
        chk("pd_ready", 8'h01, {7'h0, pd_ready});
        pd_valid = 6'((1 << n) - 1);
        @(negedge sys_clk);
        pd_valid = 6'h00;
        pd_entry = ~pd_entry;
        // an idle edge between writes keeps lane valids from being set twice in one step
        @(negedge sys_clk);
    endtask : wr

    task automatic burst(input int n);
        for (int l = 0; l < n; l++) begin
            pd_entry[l] = ent(nt, 4'h1, lq_pkg::LQ_SP_NONE, 4'h0, 5'h00);
            ex(nt, 8'h00, 3'h1, 1'b0, 1'b0);
            nt = nt + 8'h1;
        end
        wr(n);
    endtask : burst

    task automatic drain;
        for (int k = 0; k < 400 && (expq.size() != 0 || out_valid === 1'b1); k++) @(negedge sys_clk);
        chk("pending", 8'h00, 8'(expq.size()));
    endtask : drain

    task automatic flush;
        mispredict = 1'b1;
        @(negedge sys_clk);
        mispredict = 1'b0;
        expq.delete();
        ofs = 8'h00;
    endtask : flush

    // monitor: each retired decoder slot takes the oldest note; an absent note never matches
    always @(posedge sys_clk) begin
        if (rst_n && out_valid === 1'b1 && out_ready === 1'b1) begin
            for (int i = 0; i < 4; i++) begin
                if (dec_valid[i] === 1'b1) begin
                    e = (expq.size() > 0) ? expq.pop_front() : '1;
                    chk("tag", e.tag, dec_tag[i]);
                    chk("tag2", e.tag2, dec_tag2[i]);
                    chk("nuops", {5'h0, e.nu}, {5'h0, dec_nuops[i]});
                    chk("macro", {7'h0, e.mac}, {7'h0, dec_macro_fused[i]});
                    chk("micro", {7'h0, e.mic}, {7'h0, dec_micro_fused[i]});
                    chk("sp_ofs", e.ofs, dec_sp_ofs[i]);
                    chk("sp_sync", {7'h0, e.snc}, {7'h0, dec_sp_sync[i]});
                end
            end
        end
    end

    // a hang is cut short well past the expected run of a few hundred cycles
    initial begin
        #200000;
        bad_count++;
        $display("MISMATCH watchdog expected done seen hang");
        tally_and_finish();
    end

    // main sequence
    initial begin
        logic [7:0] t, w;
        void'($urandom(32'h8718));
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        hold <= 1'b0;
        for (int b = 0; b < 20; b++) burst($urandom_range(6, 1));
        drain();
        // stalled renamer: queue fills until fewer than six entries are free, then a refused burst must vanish
        hold <= 1'b1;
        repeat (2) @(negedge sys_clk);
        repeat (3) burst(6);
        repeat (2) @(negedge sys_clk);
        chk("pd_ready", 8'h00, {7'h0, pd_ready});
        pd_entry = {6{ent(8'hee, 4'h1, lq_pkg::LQ_SP_NONE, 4'h0, 5'h00)}};
        pd_valid = 6'h3f;
        @(negedge sys_clk);
        pd_valid = 6'h00;
        hold <= 1'b0;
        drain();
        // fusion, stack tracking, long flows in both modes
        for (int m = 0; m < 2; m++) begin
            mode_64 = m[0];
            w = m ? 8'h08 : 8'h04;
            t = nt;
            nt = nt + 8'h10;
            pd_entry[0] = ent(t, 4'h1, lq_pkg::LQ_SP_NONE, 4'h4, 5'h00);
            pd_entry[1] = ent(t + 8'h1, 4'h1, lq_pkg::LQ_SP_NONE, 4'h2, 5'h00);
            pd_entry[2] = ent(t + 8'h2, 4'h2, lq_pkg::LQ_SP_PUSH, 4'h0, 5'h00);
            pd_entry[3] = ent(t + 8'h3, 4'h2, lq_pkg::LQ_SP_POP, 4'h0, 5'h00);
            pd_entry[4] = ent(t + 8'h4, 4'h1, lq_pkg::LQ_SP_CALL, 4'h0, 5'h00);
            pd_entry[5] = ent(t + 8'h5, 4'h2, lq_pkg::LQ_SP_RET, 4'h0, 5'h00);
            if (m == 0) begin
                ex(t, t + 8'h1, 3'h1, 1'b1, 1'b0);
            end else begin
                ex(t, 8'h00, 3'h1, 1'b0, 1'b0);
                ex(t + 8'h1, 8'h00, 3'h1, 1'b0, 1'b0);
            end
            for (int k = 2; k < 6; k++) begin
                ofs = (k == 2 || k == 4) ? ofs - w : ofs + w;
                ex(t + 8'(k), 8'h00, 3'h1, 1'b0, 1'b0);
            end
            wr(6);
            pd_entry[0] = ent(t + 8'h6, 4'h1, lq_pkg::LQ_SP_LEAVE, 4'h0, 5'h00);
            pd_entry[1] = ent(t + 8'h7, 4'h1, lq_pkg::LQ_SP_NONE, 4'h8, 5'h00);
            pd_entry[2] = ent(t + 8'h8, 4'h4, lq_pkg::LQ_SP_NONE, 4'h0, 5'h00);
            pd_entry[3] = ent(t + 8'h9, 4'h7, lq_pkg::LQ_SP_NONE, 4'h0, 5'h00);
            ofs = w;
            snc = 1'b1;
            ex(t + 8'h6, 8'h00, 3'h1, 1'b0, 1'b0);
            snc = 1'b0;
            ex(t + 8'h7, 8'h00, 3'h1, 1'b0, 1'b1);
            ex(t + 8'h8, 8'h00, 3'h4, 1'b0, 1'b0);
            ex(t + 8'h9, 8'h00, 3'h3, 1'b0, 1'b0);
            ex(t + 8'h9, 8'h00, 3'h3, 1'b0, 1'b0);
            ex(t + 8'h9, 8'h00, 3'h1, 1'b0, 1'b0);
            wr(4);
            drain();
            flush();
        end
        // loop lengths zero and eighteen never lock
        pd_entry[0] = ent(nt, 4'h1, lq_pkg::LQ_SP_NONE, 4'h1, 5'h00);
        pd_entry[1] = ent(nt + 8'h1, 4'h1, lq_pkg::LQ_SP_NONE, 4'h1, 5'h12);
        ex(nt, 8'h00, 3'h1, 1'b0, 1'b0);
        ex(nt + 8'h1, 8'h00, 3'h1, 1'b0, 1'b0);
        nt = nt + 8'h2;
        wr(2);
        chk("fe_idle", 8'h00, {7'h0, fe_idle});
        drain();
        // three-entry loop locks and replays until a flush
        t = nt;
        for (int l = 0; l < 3; l++) pd_entry[l] = ent(t + 8'(l), 4'h1, lq_pkg::LQ_SP_NONE, 4'(l == 2), 5'(3 * (l == 2)));
        repeat (60) for (int l = 0; l < 3; l++) ex(t + 8'(l), 8'h00, 3'h1, 1'b0, 1'b0);
        nt = nt + 8'h3;
        wr(3);
        chk("fe_idle", 8'h01, {7'h0, fe_idle});
        chk("pd_ready", 8'h00, {7'h0, pd_ready});
        repeat (30) @(negedge sys_clk);
        chk("replay", 8'h01, {7'h0, expq.size() < 160});
        flush();
        chk("fe_idle", 8'h00, {7'h0, fe_idle});
        burst(2);
        drain();
        tally_and_finish();
    end
endmodule : tb

bind lq_front_end lq_fe_checker u_lq_fe_checker (.sys_clk, .rst_n, .pd_ready, .mispredict, .mode_64, .fe_idle,
    .out_ready, .out_valid, .ms_active, .dec_valid, .dec_tag, .dec_nuops, .dec_macro_fused);
